/* design/context_if.sv */
// carrier between the sequencer and the shadow register set
`default_nettype none

interface context_if;
  import irq_ctx_pkg::*;

  logic              capture;
  logic [PC_W-1:0]   pc_in;
  logic [DATA_W-1:0] acc_in;
  logic [DATA_W-1:0] status_in;
  logic [DATA_W-1:0] fsp_in;
  logic [PC_W-1:0]   pc_shadow;
  logic [DATA_W-1:0] acc_shadow;
  logic [DATA_W-1:0] status_shadow;
  logic [DATA_W-1:0] fsp_shadow;

  // sequencer side drives the live values and the capture strobe
  modport owner (
    output capture, pc_in, acc_in, status_in, fsp_in,
    input  pc_shadow, acc_shadow, status_shadow, fsp_shadow
  );

  // shadow side stores them
  modport store (
    input  capture, pc_in, acc_in, status_in, fsp_in,
    output pc_shadow, acc_shadow, status_shadow, fsp_shadow
  );
endinterface : context_if

`default_nettype wire

/* design/context_shadow.sv */
// single-level shadow register set for program counter, accumulator, status and pointer
`default_nettype none

module context_shadow (
  input  wire logic   i_clock,
  input  wire logic   i_reset,
  context_if.store    ctx
);
  import irq_ctx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // one level only: a second capture would overwrite the first context
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctx.pc_shadow     <= PC_RESET;
      ctx.acc_shadow    <= DATA_RESET;
      ctx.status_shadow <= DATA_RESET;
      ctx.fsp_shadow    <= DATA_RESET;
    end else if (ctx.capture) begin
      ctx.pc_shadow     <= ctx.pc_in;
      ctx.acc_shadow    <= ctx.acc_in;
      ctx.status_shadow <= ctx.status_in;
      ctx.fsp_shadow    <= ctx.fsp_in;
    end
  end

endmodule : context_shadow

`default_nettype wire

/* design/interrupt_context_return.sv */
// interrupt entry context save, vectoring and the two interrupt-return sequences
// What this block does
// - opcode 00Eh reloads program counter, accumulator, status and pointer from shadows.
// - both returns restore every status bit from its shadow copy.
// - interrupt entry saves 12-bit program counter, accumulator, status, pointer into shadows.
// - after saving, execution jumps to address 000h.
// - after return, fetching resumes at the restored program counter.
// - each return takes 2 cycles in compatible mode, 3 in turbo.
// - opcode 00Fh does the same restore, preceded by a timer adjustment.
// - timer-adjusting return adds accumulator to the real-time counter before restoring.
`default_nettype none

module interrupt_context_return (
  input  wire logic                            i_clock,
  input  wire logic                            i_reset,
  input  wire logic                            i_turbo_mode,
  input  wire logic                            i_irq_take,
  input  wire logic                            i_opcode_valid,
  input  wire logic [irq_ctx_pkg::PC_W-1:0]    i_opcode,
  input  wire logic [irq_ctx_pkg::PC_W-1:0]    i_pc,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0]  i_accumulator,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0]  i_status,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0]  i_file_select_pointer,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0]  i_realtime_counter,
  output logic                                 o_busy,
  output logic                                 o_isr_active,
  output logic                                 o_pc_load,
  output logic [irq_ctx_pkg::PC_W-1:0]         o_pc_value,
  output logic                                 o_acc_load,
  output logic [irq_ctx_pkg::DATA_W-1:0]       o_acc_value,
  output logic                                 o_status_load,
  output logic [irq_ctx_pkg::DATA_W-1:0]       o_status_value,
  output logic                                 o_fsp_load,
  output logic [irq_ctx_pkg::DATA_W-1:0]       o_file_select_pointer,
  output logic                                 o_rtc_load,
  output logic [irq_ctx_pkg::DATA_W-1:0]       o_realtime_counter
);
  import irq_ctx_pkg::*;

  state_t            state_reg;
  logic [1:0]        cnt_reg;
  logic              ret_ok;
  logic              ret_adjust;
  logic              take_ok;
  logic              restore_now;
  logic [DATA_W-1:0] adjust_sum;

  context_if ctx ();

  ////////////////////////////////////////////////////////////////////////////
  // request qualification
  // a return wins over a simultaneous entry; the core keeps its entry request up
  assign ret_ok      = (state_reg == S_IDLE) && i_opcode_valid && opcode_is_return(i_opcode);
  assign ret_adjust  = ret_ok && (i_opcode == OPC_RETURN_ADJ);
  assign take_ok     = (state_reg == S_IDLE) && i_irq_take && !o_isr_active && !ret_ok;
  assign restore_now = (state_reg == S_EXEC) && (cnt_reg == 2'h1);
  // counter wraps modulo 256 like the real counter
  assign adjust_sum  = DATA_W'(i_realtime_counter + i_accumulator);

  // live context goes to the shadow set, captured on entry only
  assign ctx.capture   = take_ok;
  assign ctx.pc_in     = i_pc;
  assign ctx.acc_in    = i_accumulator;
  assign ctx.status_in = i_status;
  assign ctx.fsp_in    = i_file_select_pointer;

  context_shadow u_shadow (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .ctx     (ctx.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (ret_ok) begin
            state_reg <= S_EXEC;
          end else if (take_ok) begin
            state_reg <= S_LAST;
          end
        end
        S_EXEC: begin
          if (cnt_reg == 2'h1) begin
            state_reg <= S_LAST;
          end
        end
        S_LAST:  state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // cycle counter: loaded with the mode's length less one, restore fires at one
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_reg <= CNT_RESET;
    end else if (ret_ok) begin
      cnt_reg <= return_cycles(i_turbo_mode) - 2'h1;
    end else if (state_reg == S_EXEC) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end

  // busy covers every cycle of a return and the entry cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_busy <= 1'b0;
    end else if (state_reg == S_IDLE) begin
      o_busy <= ret_ok || take_ok;
    end else if (state_reg == S_LAST) begin
      o_busy <= 1'b0;
    end
  end

  // service routine flag, which blocks nesting
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_isr_active <= 1'b0;
    end else if (take_ok) begin
      o_isr_active <= 1'b1;
    end else if (restore_now) begin
      o_isr_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer adjustment in the first cycle, one cycle before the accumulator is restored in compatible mode, two in turbo
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rtc_load         <= 1'b0;
      o_realtime_counter <= DATA_RESET;
    end else begin
      o_rtc_load <= ret_adjust;
      if (ret_adjust) begin
        o_realtime_counter <= adjust_sum;
      end
    end
  end

  // program counter: vector on entry, shadow on return
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_pc_load  <= 1'b0;
      o_pc_value <= PC_RESET;
    end else begin
      o_pc_load <= take_ok || restore_now;
      if (take_ok) begin
        o_pc_value <= VECTOR_ADDR;
      end else if (restore_now) begin
        o_pc_value <= ctx.pc_shadow;
      end
    end
  end

  // accumulator, status and pointer reload in the last cycle of either return
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_acc_load            <= 1'b0;
      o_status_load         <= 1'b0;
      o_fsp_load            <= 1'b0;
      o_acc_value           <= DATA_RESET;
      o_status_value        <= DATA_RESET;
      o_file_select_pointer <= DATA_RESET;
    end else begin
      o_acc_load    <= restore_now;
      o_status_load <= restore_now;
      o_fsp_load    <= restore_now;
      if (restore_now) begin
        o_acc_value           <= ctx.acc_shadow;
        o_status_value        <= ctx.status_shadow;                              // whole byte
        o_file_select_pointer <= ctx.fsp_shadow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_restore;
    o_pc_load && o_acc_load && o_status_load && o_fsp_load;
  endsequence

  sequence s_busy2;
    o_busy [*2] ##1 !o_busy;
  endsequence

  sequence s_busy3;
    o_busy [*3] ##1 !o_busy;
  endsequence

  property p_plain_return;
    (ret_ok && (i_opcode == OPC_RETURN) && i_turbo_mode) |-> ##3 s_restore;
  endproperty
  a_plain_return: assert property (p_plain_return) else $error("plain return did not restore");

  property p_status_restore;
    o_status_load |-> (o_status_value == $past(ctx.status_shadow));
  endproperty
  a_status_restore: assert property (p_status_restore) else $error("status not from shadow");

  property p_save;
    take_ok |=> (ctx.pc_shadow == $past(i_pc)) && (ctx.acc_shadow == $past(i_accumulator))
                && (ctx.status_shadow == $past(i_status)) && (ctx.fsp_shadow == $past(i_file_select_pointer));
  endproperty
  a_save: assert property (p_save) else $error("context not saved on entry");

  property p_vector;
    take_ok |=> o_pc_load && (o_pc_value == VECTOR_ADDR) && !o_acc_load && o_isr_active;
  endproperty
  a_vector: assert property (p_vector) else $error("entry did not vector");

  property p_resume;
    o_acc_load |-> o_pc_load && (o_pc_value == $past(ctx.pc_shadow));
  endproperty
  a_resume: assert property (p_resume) else $error("resume address wrong");

  property p_cycles_compat;
    (ret_ok && !i_turbo_mode) |=> s_busy2;
  endproperty
  a_cycles_compat: assert property (p_cycles_compat) else $error("compatible return length wrong");

  property p_cycles_turbo;
    (ret_ok && i_turbo_mode) |=> s_busy3;
  endproperty
  a_cycles_turbo: assert property (p_cycles_turbo) else $error("turbo return length wrong");

  property p_adjust_return;
    (ret_adjust && !i_turbo_mode) |-> ##2 s_restore;
  endproperty
  a_adjust_return: assert property (p_adjust_return) else $error("adjusting return did not restore");

  property p_adjust_first;
    ret_adjust |=> o_rtc_load && (o_realtime_counter == $past(adjust_sum)) && !o_acc_load ##1 !o_rtc_load;
  endproperty
  a_adjust_first: assert property (p_adjust_first) else $error("timer adjust wrong or late");

  property p_no_nest;
    (o_isr_active && (state_reg == S_IDLE)) |=> $stable(ctx.pc_shadow);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("shadow overwritten while in service");

endmodule : interrupt_context_return

`default_nettype wire

/* design/irq_ctx_pkg.sv */
// constants, opcodes and state codes for the interrupt context save and return logic
`default_nettype none

package irq_ctx_pkg;

  // datapath widths of the core
  localparam int unsigned PC_W   = 12;
  localparam int unsigned DATA_W = 8;

  // return opcodes recognised by this block
  localparam logic [PC_W-1:0] OPC_RETURN     = 12'h00E;
  localparam logic [PC_W-1:0] OPC_RETURN_ADJ = 12'h00F;

  // service routine entry address
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h000;

  // instruction cycles per return, by speed mode
  localparam logic [1:0] CYCLES_COMPAT = 2'h2;
  localparam logic [1:0] CYCLES_TURBO  = 2'h3;

  // values after reset
  localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [1:0]        CNT_RESET  = 2'h0;

  // sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_LAST = 2'b10
  } state_t;

  // true for either interrupt-return opcode
  function automatic logic opcode_is_return(input logic [PC_W-1:0] opc);
    opcode_is_return = (opc == OPC_RETURN) || (opc == OPC_RETURN_ADJ);
  endfunction

  // length of a return in cycles for the selected speed mode
  function automatic logic [1:0] return_cycles(input logic turbo);
    return_cycles = turbo ? CYCLES_TURBO : CYCLES_COMPAT;
  endfunction

endpackage : irq_ctx_pkg

`default_nettype wire

/* dv/core_model.sv */
// behavioural core model: live registers that follow the block's load pulses
`default_nettype none

module core_model (
  input  wire logic                           i_clock,
  input  wire logic                           i_reset,
  input  wire logic [63:0]                    i_rand,
  input  wire logic                           i_pc_load,
  input  wire logic [irq_ctx_pkg::PC_W-1:0]   i_pc_value,
  input  wire logic                           i_acc_load,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0] i_acc_value,
  input  wire logic                           i_status_load,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0] i_status_value,
  input  wire logic                           i_fsp_load,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0] i_fsp_value,
  input  wire logic                           i_rtc_load,
  input  wire logic [irq_ctx_pkg::DATA_W-1:0] i_rtc_value,
  output logic      [irq_ctx_pkg::PC_W-1:0]   o_pc,
  output logic      [irq_ctx_pkg::DATA_W-1:0] o_acc,
  output logic      [irq_ctx_pkg::DATA_W-1:0] o_status,
  output logic      [irq_ctx_pkg::DATA_W-1:0] o_fsp,
  output logic      [irq_ctx_pkg::DATA_W-1:0] o_rtc
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctx_pkg::*;

  // every register changes each cycle as program code would, so a lost restore shows up at once
  always @(posedge i_clock) begin
    if (i_reset) begin
      {o_pc, o_acc, o_status, o_fsp, o_rtc} <= '0;
    end else begin
      o_pc     <= i_pc_load ? i_pc_value : i_rand[11:0];
      o_acc    <= i_acc_load ? i_acc_value : i_rand[19:12]; // correction left in the accumulator
      o_status <= i_status_load ? i_status_value : i_rand[27:20];
      o_fsp    <= i_fsp_load ? i_fsp_value : i_rand[35:28];
      o_rtc    <= i_rtc_load ? i_rtc_value : i_rand[43:36];
    end
  end
endmodule // core_model

`default_nettype wire

/* dv/tb.sv */
// self-checking bench for interrupt entry and the two return sequences
`default_nettype none
`define CHK(nm, ev, gv) begin n_compared++; if ((gv) !== (ev)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ev, gv); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctx_pkg::*;

  typedef struct {int cyc; logic rst; logic [PC_W-1:0] pc; logic [DATA_W-1:0] acc, st, fsp;} note_t;

  logic              clock = 1'b0;
  logic              rst   = 1'b1;
  logic              turbo = 1'b0;
  logic              irq   = 1'b0;
  logic              opv   = 1'b0;
  logic [PC_W-1:0]   opc   = 12'h000;
  logic [63:0]       rnd   = 64'h0;
  logic [PC_W-1:0]   pc, pcv;
  logic [DATA_W-1:0] acc, st, fsp, rtc, accv, stv, fspv, rtcv;
  logic              busy, act, pcl, accl, stl, fspl, rtcl;
  integer            seed = 73360, err_count = 0, n_compared = 0, cyc = 0;
  note_t             q[$], rq[$], n, rn, ctx;

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  always @(negedge clock) rnd <= {$random(seed), $random(seed)};

  interrupt_context_return i_interrupt_context_return (
    .i_clock(clock), .i_reset(rst), .i_turbo_mode(turbo), .i_irq_take(irq),
    .i_opcode_valid(opv), .i_opcode(opc), .i_pc(pc), .i_accumulator(acc), .i_status(st),
    .i_file_select_pointer(fsp), .i_realtime_counter(rtc), .o_busy(busy), .o_isr_active(act),
    .o_pc_load(pcl), .o_pc_value(pcv), .o_acc_load(accl), .o_acc_value(accv),
    .o_status_load(stl), .o_status_value(stv), .o_fsp_load(fspl), .o_file_select_pointer(fspv),
    .o_rtc_load(rtcl), .o_realtime_counter(rtcv));

  core_model i_core_model (
    .i_clock(clock), .i_reset(rst), .i_rand(rnd), .i_pc_load(pcl), .i_pc_value(pcv),
    .i_acc_load(accl), .i_acc_value(accv), .i_status_load(stl), .i_status_value(stv),
    .i_fsp_load(fspl), .i_fsp_value(fspv), .i_rtc_load(rtcl), .i_rtc_value(rtcv),
    .o_pc(pc), .o_acc(acc), .o_status(st), .o_fsp(fsp), .o_rtc(rtc));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge clock);
  endtask

  // monitor: each load pulse takes the oldest note; a load with no note is an unwanted one
  always @(negedge clock) begin
    if (pcl) begin
      if (q.size() == 0) `CHK("unexpected pc load", 1'b0, pcl)
      else begin
        n = q.pop_front();
        `CHK("load cycle", n.cyc, cyc)
        `CHK("busy during load", 1'b1, busy)
        `CHK("pc value", n.pc, pcv)
        `CHK("service active", ~n.rst, act)
        `CHK("restore loads", {3{n.rst}}, {accl, stl, fspl})
        if (n.rst) begin
          `CHK("accumulator", n.acc, accv)
          `CHK("status", n.st, stv)
          `CHK("pointer", n.fsp, fspv)
        end
      end
    end
    if (rtcl) begin
      if (rq.size() == 0) `CHK("unexpected counter load", 1'b0, rtcl)
      else begin
        rn = rq.pop_front();
        `CHK("counter cycle", rn.cyc, cyc)
        `CHK("counter value", rn.acc, rtcv)
      end
    end
  end

  // watchdog: the sequence needs under a hundred cycles
  initial begin
    #20000;
    err_count++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  // every opcode in both speed modes, each entry followed at once by the next request
  initial begin
    int i;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK("idle after reset", 3'b000, {busy, act, pcl})
    for (i = 0; i < 8; i++) begin
      irq = 1'b1;
      q.push_back('{cyc + 1, 1'b0, VECTOR_ADDR, 8'h00, 8'h00, 8'h00});
      ctx = '{0, 1'b1, pc, acc, st, fsp};
      @(negedge clock);
      // keep requesting with non-return opcodes while the routine runs; both must be ignored
      repeat (3) begin
        opv = 1'b1;
        opc = {rnd[11:4] | 8'h01, rnd[3:0]};
        @(negedge clock);
      end
      irq = 1'b0;
      // the service routine ends with a return opcode
      turbo = i[0];
      opc = i[1] ? OPC_RETURN_ADJ : OPC_RETURN;
      if (i[1]) rq.push_back('{cyc + 1, 1'b0, 12'h000, acc + rtc, 8'h00, 8'h00});
      ctx.cyc = cyc + (i[0] ? 3 : 2);
      q.push_back(ctx);
      @(negedge clock);
      opc = OPC_RETURN; // a second return while busy is dropped
      @(negedge clock);
      opv = 1'b0;
      wait_idle();
    end
    repeat (4) @(negedge clock);
    `CHK("notes left", 0, q.size() + rq.size())
    stop_test();
  end
endmodule // tb

`undef CHK
`default_nettype wire
